// File: data_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_map
	import dmem_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire cmd_type cmd,
	input wire logic reg_we,
	input wire sel_type reg_sel,
	input wire logic [7:0] reg_wdata,
	input wire periph_type periph,
	output logic cmd_ready,
	output logic done,
	output result_type result,
	output core_type core,
	output ctrl_type ctrl
);
	typedef enum logic [2:0] {S_IDLE, S_PTR_LO, S_PTR_HI, S_ACCESS, S_PUSH, S_POP_INC, S_POP_RD} fsm_type;

	typedef struct packed {
		fsm_type state;
		logic ready;
		logic done;
		result_type result;
		core_type core;
		ctrl_type ctrl;
		cmd_type cmd;
		logic [15:0] addr;
		logic [7:0] ptr_lo;
		logic [23:0] stk;
		logic [1:0] count;
	} state_type;

	state_type st;
	state_type next_st;
	logic [7:0] ram [RAM_DEPTH];
	logic [7:0] ram_q;
	logic [7:0] rd_byte;
	logic [8:0] rmw_out;
	logic wr_en;
	logic [15:0] wr_addr;
	logic [7:0] wr_data;

	// effective address for the first access; indirect modes give the pointer location
	function automatic logic [15:0] ea_calc(mode_type m, logic [7:0] lo, logic [7:0] hi, logic [7:0] x,
		logic [7:0] y);
		logic [7:0] dsum;
		dsum = 8'h00;
		ea_calc = {8'h00, lo}; // [RQ12] [RQ20]
		unique case (m)
			MODE_ABS: ea_calc = {hi, lo}; // [RQ13]
			MODE_X, MODE_X_INC: ea_calc = {8'h00, x}; // [RQ15]
			MODE_DP_X, MODE_DP_X_IND: begin
				dsum = lo + x; // [RQ24]
				ea_calc = {8'h00, dsum}; // [RQ17] [RQ21]
			end
			MODE_DP_Y: begin
				dsum = lo + y; // [RQ24]
				ea_calc = {8'h00, dsum}; // [RQ18]
			end
			MODE_ABS_Y: ea_calc = {hi, lo} + {8'h00, y}; // [RQ19]
			default: ea_calc = {8'h00, lo};
		endcase
	endfunction : ea_calc

	// byte modifier for read-modify-write; returns {carry, value}
	function automatic logic [8:0] rmw_calc(rmw_type f, logic [7:0] v, logic c);
		rmw_calc = {c, v};
		unique case (f)
			RMW_SHL: rmw_calc = {v[7], v[6:0], 1'b0};
			RMW_SHR: rmw_calc = {v[0], 1'b0, v[7:1]};
			RMW_ROL: rmw_calc = {v[7], v[6:0], c};
			RMW_ROR: rmw_calc = {v[0], c, v[7:1]};
			RMW_INC: rmw_calc = {c, v + 8'h01};
			RMW_DEC: rmw_calc = {c, v - 8'h01};
			RMW_TEST: rmw_calc = {c, v};
		endcase
	endfunction : rmw_calc

	// register-addressed read, no memory cycle involved
	function automatic logic [7:0] reg_read(core_type k, sel_type s);
		reg_read = k.acc;
		unique case (s)
			SEL_ACC: reg_read = k.acc;
			SEL_X: reg_read = k.x;
			SEL_Y: reg_read = k.y;
			SEL_CARRY: reg_read = {7'h00, k.program_status_word[CARRY_BIT]};
			SEL_STATUS: reg_read = k.program_status_word;
			SEL_STACK: reg_read = k.stack_pointer;
		endcase
	endfunction : reg_read

	// register-addressed write, shared by the register port and register-mode stores
	function automatic core_type reg_write(core_type k, sel_type s, logic [7:0] d);
		reg_write = k;
		unique case (s)
			SEL_ACC: reg_write.acc = d;
			SEL_X: reg_write.x = d;
			SEL_Y: reg_write.y = d;
			SEL_CARRY: reg_write.program_status_word[CARRY_BIT] = d[0];
			SEL_STATUS: reg_write.program_status_word = d;
			SEL_STACK: reg_write.stack_pointer = d;
		endcase
	endfunction : reg_write

	// read decode; shared addresses return the live peripheral value, except 0xD4, which returns the PWM duty in PWM mode; holes read as zero
	function automatic logic [7:0] map_read(logic [15:0] a, ctrl_type c, periph_type p, logic [7:0] rq);
		map_read = 8'h00; // [RQ3]
		if (a < RAM_LIMIT) begin
			map_read = rq; // [RQ1]
		end else if (a[15:8] == 8'h00) begin
			unique case (a[7:0]) // [RQ2]
				ADDR_PORT_DATA: map_read = p.port_pins;
				ADDR_TIMER_A_MODE: map_read = c.timer_a_mode;
				ADDR_TIMER_A_DATA: map_read = c.timer_a_mode[TIMER_A_CAPTURE_BIT] ?
					p.timer_a_capture_data : p.timer_a_count; // [RQ6]
				ADDR_TIMER_B_MODE: map_read = c.timer_b_mode;
				ADDR_TIMER_B_COUNT: begin
					if (c.timer_b_mode[TIMER_B_PWM_BIT]) begin
						map_read = c.pwm_duty; // [RQ6]
					end else if (c.timer_a_mode[TIMER_A_CAPTURE_BIT]) begin
						map_read = p.timer_b_capture_data;
					end else begin
						map_read = p.timer_b_count;
					end
				end
				ADDR_INTERVAL: map_read = p.interval_timer_count; // [RQ5]
				ADDR_WATCHDOG: map_read = p.watchdog_counter_read;
				ADDR_IRQ_ENABLE: map_read = c.interrupt_enable_high;
				ADDR_IRQ_REQUEST: map_read = c.interrupt_request_high;
				ADDR_EDGE_SELECT: map_read = c.ext_interrupt_edge_select;
				ADDR_CONV_MODE: map_read = c.converter_mode;
				ADDR_CONV_RESULT: map_read = p.converter_result;
				ADDR_SYS_STATUS: map_read = c.system_status;
				ADDR_OSC_CAL: map_read = c.internal_osc_calibration;
				ADDR_POWER_FAIL: map_read = c.power_fail_control;
				default: map_read = 8'h00;
			endcase
		end
	endfunction : map_read

	// write decode; only 0xD3 steers into the register that the timer B mode selects, other shared addresses write one fixed register
	function automatic ctrl_type ctrl_write(ctrl_type c, logic [7:0] a, logic [7:0] d);
		ctrl_write = c;
		unique case (a) // [RQ2]
			ADDR_PORT_DATA: ctrl_write.port_pin_data = d;
			ADDR_PORT_DIR: ctrl_write.port_direction = d;
			ADDR_PORT_OD: ctrl_write.port_open_drain_select = d;
			ADDR_PORT_PULLUP: ctrl_write.port_pullup_select = d;
			ADDR_PORT_ALT: ctrl_write.port_alt_function_select = d;
			ADDR_PORT_KEYSCAN: ctrl_write.port_keyscan_select = d;
			ADDR_TIMER_A_MODE: ctrl_write.timer_a_mode = d;
			ADDR_TIMER_A_DATA: ctrl_write.timer_a_compare_data = d; // [RQ6]
			ADDR_TIMER_B_MODE: ctrl_write.timer_b_mode = d;
			ADDR_TIMER_B_DATA: begin
				if (c.timer_b_mode[TIMER_B_PWM_BIT]) begin
					ctrl_write.pwm_period = d; // [RQ6]
				end else begin
					ctrl_write.timer_b_compare_data = d;
				end
			end
			ADDR_TIMER_B_COUNT: ctrl_write.pwm_duty = d; // [RQ6]
			ADDR_PWM_HIGH: ctrl_write.pwm_high_bits = d;
			ADDR_INTERVAL: ctrl_write.clock_interval_control = d; // [RQ5]
			ADDR_WATCHDOG: ctrl_write.watchdog_compare_write = d;
			ADDR_IRQ_ENABLE: ctrl_write.interrupt_enable_high = d;
			ADDR_IRQ_REQUEST: ctrl_write.interrupt_request_high = d;
			ADDR_EDGE_SELECT: ctrl_write.ext_interrupt_edge_select = d;
			ADDR_CONV_MODE: ctrl_write.converter_mode = d;
			ADDR_SYS_STATUS: ctrl_write.system_status = d;
			ADDR_OSC_CAL: ctrl_write.internal_osc_calibration = d;
			ADDR_POWER_FAIL: ctrl_write.power_fail_control = d;
			ADDR_STOP_SLEEP: ctrl_write.stop_sleep_control = d;
			default: ctrl_write = c; // [RQ3]
		endcase
	endfunction : ctrl_write

	// user RAM reads asynchronously so a read-modify-write fits in one cycle
	assign ram_q = ram[st.addr[6:0]];
	assign rd_byte = map_read(st.addr, st.ctrl, periph, ram_q);
	assign rmw_out = rmw_calc(st.cmd.rmw, rd_byte, st.core.program_status_word[CARRY_BIT]);

	// sequencer: one byte access per cycle, pointer and stack steps walk through states
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		wr_en = 1'b0;
		wr_addr = st.addr;
		wr_data = 8'h00;
		unique case (st.state)
			S_IDLE: begin
				if (cmd_valid) begin
					next_st.cmd = cmd;
					next_st.addr = ea_calc(cmd.mode, cmd.operand_lo, cmd.operand_hi, st.core.x, st.core.y);
					next_st.result.ea = next_st.addr;
					unique case (cmd.op)
						OP_CALL: begin
							next_st.stk = {cmd.pc, 8'h00}; // [RQ7]
							next_st.count = 2'd2;
							next_st.state = S_PUSH;
						end
						OP_INTR: begin
							next_st.stk = {cmd.pc, st.core.program_status_word}; // [RQ7]
							next_st.count = 2'd3;
							next_st.state = S_PUSH;
						end
						OP_SUBROUTINE_RETURN: begin
							next_st.count = 2'd2; // [RQ8]
							next_st.state = S_POP_INC;
						end
						OP_INTERRUPT_RETURN: begin
							next_st.count = 2'd3; // [RQ8]
							next_st.state = S_POP_INC;
						end
						default: begin
							unique case (cmd.mode)
								MODE_REG: begin
									next_st.result.data = reg_read(st.core, cmd.sel); // [RQ10]
									if (cmd.op == OP_STORE) begin
										next_st.core = reg_write(st.core, cmd.sel, cmd.wdata); // [RQ10]
									end
									next_st.done = 1'b1;
								end
								MODE_IMM: begin
									next_st.result.data = cmd.operand_lo; // [RQ11]
									next_st.done = 1'b1;
								end
								MODE_DP_IND, MODE_DP_X_IND, MODE_DP_IND_Y: next_st.state = S_PTR_LO;
								default: next_st.state = S_ACCESS;
							endcase
						end
					endcase
				end else if (reg_we) begin
					next_st.core = reg_write(st.core, reg_sel, reg_wdata); // [RQ23]
				end
			end
			S_PTR_LO: begin
				next_st.ptr_lo = rd_byte; // [RQ21] [RQ22]
				next_st.addr = {8'h00, st.addr[7:0] + 8'h01}; // [RQ24]
				next_st.state = S_PTR_HI;
			end
			S_PTR_HI: begin
				next_st.addr = {rd_byte, st.ptr_lo}; // [RQ20]
				if (st.cmd.mode == MODE_DP_IND_Y) begin
					next_st.addr = {rd_byte, st.ptr_lo} + {8'h00, st.core.y}; // [RQ22]
				end
				next_st.result.ea = next_st.addr;
				if (st.cmd.op == OP_TARGET) begin
					next_st.done = 1'b1;
					next_st.state = S_IDLE;
				end else begin
					next_st.state = S_ACCESS;
				end
			end
			S_ACCESS: begin
				unique case (st.cmd.op)
					OP_STORE: begin
						wr_en = 1'b1;
						wr_data = st.cmd.wdata;
					end
					OP_RMW: begin
						next_st.result.data = rmw_out[7:0];
						wr_en = (st.cmd.rmw != RMW_TEST); // [RQ14]
						wr_data = rmw_out[7:0];
						next_st.core.program_status_word[CARRY_BIT] = rmw_out[8];
					end
					default: next_st.result.data = rd_byte;
				endcase
				if (st.cmd.mode == MODE_X_INC) begin
					next_st.core.x = st.core.x + 8'h01; // [RQ16]
				end
				next_st.done = 1'b1;
				next_st.state = S_IDLE;
			end
			S_PUSH: begin
				// save first, then move the pointer down to the next free slot
				wr_en = 1'b1;
				wr_addr = {8'h00, st.core.stack_pointer}; // [RQ1]
				wr_data = st.stk[23:16];
				next_st.stk = {st.stk[15:0], 8'h00};
				next_st.core.stack_pointer = st.core.stack_pointer - 8'h01; // [RQ9]
				next_st.count = st.count - 2'd1;
				if (st.count == 2'd1) begin
					next_st.done = 1'b1;
					next_st.state = S_IDLE;
				end
			end
			S_POP_INC: begin
				next_st.core.stack_pointer = st.core.stack_pointer + 8'h01; // [RQ9]
				next_st.addr = {8'h00, next_st.core.stack_pointer};
				next_st.state = S_POP_RD;
			end
			S_POP_RD: begin
				next_st.stk = {rd_byte, st.stk[23:8]};
				next_st.count = st.count - 2'd1;
				next_st.state = S_POP_INC;
				if (st.count == 2'd1) begin
					next_st.result.pc = next_st.stk[23:8]; // [RQ8]
					if (st.cmd.op == OP_INTERRUPT_RETURN) begin
						next_st.core.program_status_word = next_st.stk[7:0]; // [RQ8]
					end
					next_st.done = 1'b1;
					next_st.state = S_IDLE;
				end
			end
			default: next_st.state = S_IDLE;
		endcase
		if (wr_en && wr_addr >= RAM_LIMIT && wr_addr[15:8] == 8'h00) begin
			next_st.ctrl = ctrl_write(st.ctrl, wr_addr[7:0], wr_data);
		end
		next_st.ready = (next_st.state == S_IDLE);
	end

	// state register; the stack pointer keeps its value through reset on purpose
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.ctrl <= CTRL_RESET;
			st.ready <= 1'b1;
			st.state <= S_IDLE;
			st.core.stack_pointer <= st.core.stack_pointer; // [RQ23]
		end else begin
			st <= next_st;
		end
	end

	// user RAM, no reset: contents are undefined until software writes them
	always_ff @(posedge clk) begin
		if (rst_n && wr_en && wr_addr < RAM_LIMIT) begin
			ram[wr_addr[6:0]] <= wr_data; // [RQ1]
		end
	end

	assign cmd_ready = st.ready;
	assign done = st.done;
	assign result = st.result;
	assign core = st.core;
	assign ctrl = st.ctrl;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_call_taken;
		cmd_valid && st.ready && cmd.op == OP_CALL;
	endsequence
	sequence s_two_saves;
		(st.state == S_PUSH)[*2] ##1 (st.done && st.state == S_IDLE);
	endsequence
	property p_call_saves;
		s_call_taken |=> s_two_saves;
	endproperty
	a_call_saves: assert property (p_call_saves) else $error("call did not save two bytes"); // [RQ7]

	property p_push_down;
		st.state == S_PUSH |=> st.core.stack_pointer == $past(st.core.stack_pointer) - 8'h01;
	endproperty
	a_push_down: assert property (p_push_down) else $error("stack pointer not decremented"); // [RQ9]

	property p_push_slot;
		st.state == S_PUSH |=> ram[$past(st.core.stack_pointer[6:0])] == $past(st.stk[23:16]);
	endproperty
	a_push_slot: assert property (p_push_slot) else $error("saved byte missing"); // [RQ9]

	property p_intr_return;
		(st.state == S_POP_RD && st.cmd.op == OP_INTERRUPT_RETURN && st.count == 2'd1) |=>
			(st.core.program_status_word == $past(st.stk[15:8]) && st.result.pc == {$past(rd_byte),
			$past(st.stk[23:16])});
	endproperty
	a_intr_return: assert property (p_intr_return) else $error("interrupt return restore wrong"); // [RQ8]

	property p_sub_return;
		(st.state == S_POP_RD && st.cmd.op == OP_SUBROUTINE_RETURN && st.count == 2'd1) |=>
			$stable(st.core.program_status_word) && st.done;
	endproperty
	a_sub_return: assert property (p_sub_return) else $error("subroutine return touched status"); // [RQ8]

	property p_immediate;
		(cmd_valid && st.ready && cmd.mode == MODE_IMM && cmd.op == OP_LOAD) |=>
			st.done && st.result.data == $past(cmd.operand_lo);
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate data wrong"); // [RQ11]

	property p_auto_inc;
		(st.state == S_ACCESS && st.cmd.mode == MODE_X_INC) |=> st.core.x == $past(st.core.x) + 8'h01;
	endproperty
	a_auto_inc: assert property (p_auto_inc) else $error("auto increment missing"); // [RQ16]

	property p_interval_read;
		(st.state == S_ACCESS && st.cmd.op == OP_LOAD && st.addr == 16'h00E0) |=>
			st.result.data == $past(periph.interval_timer_count);
	endproperty
	a_interval_read: assert property (p_interval_read) else $error("interval count read wrong"); // [RQ5]

	property p_interval_write;
		(st.state == S_ACCESS && st.cmd.op == OP_STORE && st.addr == 16'h00E0) |=>
			st.ctrl.clock_interval_control == $past(st.cmd.wdata);
	endproperty
	a_interval_write: assert property (p_interval_write) else $error("clock control write lost"); // [RQ5]

	property p_period_write;
		(st.state == S_ACCESS && st.cmd.op == OP_STORE && st.addr == 16'h00D3 &&
			st.ctrl.timer_b_mode[TIMER_B_PWM_BIT]) |=> st.ctrl.pwm_period == $past(st.cmd.wdata);
	endproperty
	a_period_write: assert property (p_period_write) else $error("period write lost"); // [RQ6]

	property p_far_read;
		(st.state == S_ACCESS && st.cmd.op == OP_LOAD && st.addr[15:8] != 8'h00) |=> st.result.data == 8'h00;
	endproperty
	a_far_read: assert property (p_far_read) else $error("out of window read not zero"); // [RQ2]
endmodule : data_memory_map
`default_nettype wire

// File: dmem_pkg.sv
// Behaviour
// RQ1: 128 bytes of user RAM at the bottom of data memory, also holding the stack.
// RQ2: control registers decode only in the upper window ending at 0xFF.
// RQ3: unused control addresses read as zero and ignore writes.
// RQ4: the CPU writes write-only registers with whole bytes, never read-modify-write.
// RQ5: address 0xE0 reads the interval count and writes clock/interval control.
// RQ6: shared timer addresses read count/capture/duty and write compare/period/duty by mode.
// RQ7: call and interrupt acceptance save the return counter on the stack first.
// RQ8: subroutine return restores the counter; interrupt return also restores status.
// RQ9: stack pointer decrements after each save and increments before each restore.
// RQ10: register addressing selects accumulator, X, Y, carry or status without memory.
// RQ11: immediate addressing returns the operand byte itself as data.
// RQ12: direct page addressing uses the operand as a direct-page address.
// RQ13: absolute addressing uses second byte low, third byte high.
// RQ14: absolute shift, rotate, increment, decrement and test read-modify-write memory.
// RQ15: X-only addressing uses X as the direct-page address.
// RQ16: auto-increment accesses the location in X, then adds one to X.
// RQ17: X-offset direct page address is operand plus X.
// RQ18: Y-offset direct page address is operand plus Y.
// RQ19: Y-indexed absolute address is the 16-bit operand plus Y.
// RQ20: direct page indirect fetches a two-byte jump or call target.
// RQ21: X-indexed indirect reads a pointer at operand plus X, low byte first.
// RQ22: indirect-then-Y reads a pointer at the operand, low first, then adds Y.
// RQ23: stack pointer is not reset; software loads it before use.
// RQ24: direct-page address sums wrap within eight bits.
package dmem_pkg;
	localparam int RAM_DEPTH = 128;
	localparam logic [15:0] RAM_LIMIT = 16'h0080;
	localparam logic [7:0] ADDR_PORT_DATA = 8'hC0;
	localparam logic [7:0] ADDR_PORT_DIR = 8'hC1;
	localparam logic [7:0] ADDR_PORT_OD = 8'hC2;
	localparam logic [7:0] ADDR_PORT_PULLUP = 8'hC3;
	localparam logic [7:0] ADDR_PORT_ALT = 8'hC4;
	localparam logic [7:0] ADDR_PORT_KEYSCAN = 8'hC5;
	localparam logic [7:0] ADDR_TIMER_A_MODE = 8'hD0;
	localparam logic [7:0] ADDR_TIMER_A_DATA = 8'hD1;
	localparam logic [7:0] ADDR_TIMER_B_MODE = 8'hD2;
	localparam logic [7:0] ADDR_TIMER_B_DATA = 8'hD3;
	localparam logic [7:0] ADDR_TIMER_B_COUNT = 8'hD4;
	localparam logic [7:0] ADDR_PWM_HIGH = 8'hD5;
	localparam logic [7:0] ADDR_INTERVAL = 8'hE0;
	localparam logic [7:0] ADDR_WATCHDOG = 8'hE2;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hE3;
	localparam logic [7:0] ADDR_IRQ_REQUEST = 8'hE5;
	localparam logic [7:0] ADDR_EDGE_SELECT = 8'hE7;
	localparam logic [7:0] ADDR_CONV_MODE = 8'hE8;
	localparam logic [7:0] ADDR_CONV_RESULT = 8'hE9;
	localparam logic [7:0] ADDR_SYS_STATUS = 8'hEC;
	localparam logic [7:0] ADDR_OSC_CAL = 8'hED;
	localparam logic [7:0] ADDR_POWER_FAIL = 8'hEE;
	localparam logic [7:0] ADDR_STOP_SLEEP = 8'hEF;
	localparam int TIMER_A_CAPTURE_BIT = 5;
	localparam int TIMER_B_PWM_BIT = 5;
	localparam int CARRY_BIT = 0;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	localparam logic [7:0] RESET_TIMER_DATA = 8'hFF;
	localparam logic [7:0] RESET_CLOCK_CTRL = 8'h17;
	localparam logic [7:0] RESET_WATCHDOG = 8'h7F;

	typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_RMW, OP_TARGET, OP_CALL, OP_INTR,
		OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN} op_type;
	typedef enum logic [3:0] {MODE_REG, MODE_IMM, MODE_DP, MODE_ABS, MODE_X, MODE_X_INC, MODE_DP_X,
		MODE_DP_Y, MODE_ABS_Y, MODE_DP_IND, MODE_DP_X_IND, MODE_DP_IND_Y} mode_type;
	typedef enum logic [2:0] {RMW_SHL, RMW_SHR, RMW_ROL, RMW_ROR, RMW_INC, RMW_DEC, RMW_TEST} rmw_type;
	typedef enum logic [2:0] {SEL_ACC, SEL_X, SEL_Y, SEL_CARRY, SEL_STATUS, SEL_STACK} sel_type;

	typedef struct packed {
		op_type op;
		mode_type mode;
		rmw_type rmw;
		sel_type sel;
		logic [7:0] operand_lo;
		logic [7:0] operand_hi;
		logic [7:0] wdata;
		logic [15:0] pc;
	} cmd_type;

	typedef struct packed {
		logic [7:0] data;
		logic [15:0] ea;
		logic [15:0] pc;
	} result_type;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] x;
		logic [7:0] y;
		logic [7:0] program_status_word;
		logic [7:0] stack_pointer;
	} core_type;

	typedef struct packed {
		logic [7:0] port_pins;
		logic [7:0] timer_a_count;
		logic [7:0] timer_a_capture_data;
		logic [7:0] timer_b_count;
		logic [7:0] timer_b_capture_data;
		logic [7:0] interval_timer_count;
		logic [7:0] watchdog_counter_read;
		logic [7:0] converter_result;
	} periph_type;

	typedef struct packed {
		logic [7:0] port_pin_data;
		logic [7:0] port_direction;
		logic [7:0] port_open_drain_select;
		logic [7:0] port_pullup_select;
		logic [7:0] port_alt_function_select;
		logic [7:0] port_keyscan_select;
		logic [7:0] timer_a_mode;
		logic [7:0] timer_a_compare_data;
		logic [7:0] timer_b_mode;
		logic [7:0] timer_b_compare_data;
		logic [7:0] pwm_period;
		logic [7:0] pwm_duty;
		logic [7:0] pwm_high_bits;
		logic [7:0] clock_interval_control;
		logic [7:0] watchdog_compare_write;
		logic [7:0] interrupt_enable_high;
		logic [7:0] interrupt_request_high;
		logic [7:0] ext_interrupt_edge_select;
		logic [7:0] converter_mode;
		logic [7:0] system_status;
		logic [7:0] internal_osc_calibration;
		logic [7:0] power_fail_control;
		logic [7:0] stop_sleep_control;
	} ctrl_type;

	localparam ctrl_type CTRL_RESET = '{RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO,
		RESET_ZERO, RESET_ZERO, RESET_TIMER_DATA, RESET_ZERO, RESET_TIMER_DATA, RESET_TIMER_DATA,
		RESET_ZERO, RESET_ZERO, RESET_CLOCK_CTRL, RESET_WATCHDOG, RESET_ZERO, RESET_ZERO, RESET_ZERO,
		RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO};
endpackage : dmem_pkg

// File: cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// cpu side of the block: drives the command and register ports just after each rising edge
module cpu_model
	import dmem_pkg::*;
(
	input wire logic clk,
	input wire logic cmd_ready,
	input wire logic done,
	output logic cmd_valid,
	output cmd_type cmd,
	output logic reg_we,
	output sel_type reg_sel,
	output logic [7:0] reg_wdata
);
	// idle levels from time zero
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		reg_we = 1'b0;
		reg_sel = SEL_ACC;
		reg_wdata = 8'h00;
	end
	// one whole-byte command at a time, issued only while idle, never read-modify-write on write-only places
	task automatic issue(input cmd_type c, output logic ok);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		cmd = c;
		cmd_valid = 1'b1;
		// hold the request until an edge at which the block shows ready
		while (cmd_ready !== 1'b1 && n < 12) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		cmd = ~c; // released fields stop showing the old request
		while (done !== 1'b1 && n < 12) begin
			@(posedge clk);
			#1;
			n++;
		end
		ok = done;
	endtask : issue
	// register port used only while idle; the stack pointer is loaded here before any stack use
	task automatic write_reg(input sel_type s, input logic [7:0] v);
		@(posedge clk);
		#1;
		reg_sel = s;
		reg_wdata = v;
		reg_we = 1'b1;
		@(posedge clk);
		#1;
		reg_we = 1'b0;
		reg_wdata = ~v;
	endtask : write_reg
endmodule : cpu_model
`default_nettype wire

// File: data_memory_map_and_addressing_test.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_map_and_addressing_test;
	import dmem_pkg::*;
	logic clk, rst_n, reg_we, cmd_valid, cmd_ready, done;
	sel_type reg_sel;
	logic [7:0] reg_wdata, v;
	periph_type periph;
	cmd_type cmd;
	result_type result;
	core_type core;
	ctrl_type ctrl;
	int n_mismatch = 0, checks_done = 0, seed = 43682;
	logic [7:0] mem [0:255];
	logic [15:0] pc;
	logic [8:0] e;
	rmw_type fn = RMW_INC;
	data_memory_map uut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .reg_we(reg_we),
		.reg_sel(reg_sel), .reg_wdata(reg_wdata), .periph(periph), .cmd_ready(cmd_ready), .done(done),
		.result(result), .core(core), .ctrl(ctrl));
	cpu_model cpu (.clk(clk), .cmd_ready(cmd_ready), .done(done), .cmd_valid(cmd_valid), .cmd(cmd),
		.reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata));
	// 125 MHz
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [183:0] exp, input logic [183:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	// one command through the cpu model, which must complete within its bound
	task automatic run(input op_type op, input mode_type m, input sel_type s, input logic [7:0] lo,
		input logic [7:0] hi, input logic [7:0] wd);
		logic ok;
		cpu.issue('{op, m, fn, s, lo, hi, wd, pc}, ok);
		chk("done and ready", 2'b11, {ok, cmd_ready});
	endtask : run
	// direct-page store kept in step with the memory model
	task automatic st(input logic [7:0] a, input logic [7:0] d);
		run(OP_STORE, MODE_DP, SEL_ACC, a, 8'h00, d);
		mem[a] = d;
	endtask : st
	task automatic ld(input string what, input mode_type m, input logic [7:0] lo, input logic [7:0] hi,
		input logic [15:0] ea, input logic [7:0] d);
		run(OP_LOAD, m, SEL_ACC, lo, hi, 8'h00);
		chk(what, {ea, d}, {result.ea, result.data});
	endtask : ld
	// main sequence
	initial begin
		rst_n = 1'b0;
		periph = {$random(seed), $random(seed)};
		pc = 16'h0000;
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("ctrl reset", CTRL_RESET, ctrl);
		cpu.write_reg(SEL_STACK, 8'h7F);
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed)) & 8'h7F;
			st(v, 8'($random(seed)));
			ld("ram", MODE_DP, v, 8'h00, {8'h00, v}, mem[v]);
		end
		for (int i = 0; i < 5; i++) begin
			v = 8'($random(seed));
			cpu.write_reg(sel_type'(i), v);
			run(OP_LOAD, MODE_REG, sel_type'(i), 8'h00, 8'h00, 8'h00);
			chk("reg", (i == 3) ? {7'h00, v[0]} : v, result.data);
		end
		run(OP_LOAD, MODE_IMM, SEL_ACC, v, 8'h00, 8'h00);
		chk("imm", v, result.data);
		run(OP_STORE, MODE_DP, SEL_ACC, 8'hE0, 8'h00, v);
		chk("clock ctrl", v, ctrl.clock_interval_control);
		ld("interval", MODE_DP, 8'hE0, 8'h00, 16'h00E0, periph.interval_timer_count);
		run(OP_STORE, MODE_DP, SEL_ACC, 8'hD3, 8'h00, v);
		run(OP_STORE, MODE_DP, SEL_ACC, 8'hD2, 8'h00, 8'h20);
		run(OP_STORE, MODE_DP, SEL_ACC, 8'hD3, 8'h00, ~v);
		chk("period", {~v, v}, {ctrl.pwm_period, ctrl.timer_b_compare_data});
		run(OP_STORE, MODE_DP, SEL_ACC, 8'hD4, 8'h00, v);
		ld("duty", MODE_DP, 8'hD4, 8'h00, 16'h00D4, v);
		ld("count a", MODE_DP, 8'hD1, 8'h00, 16'h00D1, periph.timer_a_count);
		run(OP_STORE, MODE_DP, SEL_ACC, 8'hD0, 8'h00, 8'h20);
		ld("capture a", MODE_DP, 8'hD1, 8'h00, 16'h00D1, periph.timer_a_capture_data);
		ld("write only", MODE_DP, 8'hC1, 8'h00, 16'h00C1, 8'h00);
		ld("unmapped", MODE_DP, 8'h90, 8'h00, 16'h0090, 8'h00);
		pc = 16'($random(seed));
		run(OP_CALL, MODE_DP, SEL_ACC, 8'h00, 8'h00, 8'h00);
		chk("sp call", 8'h7D, core.stack_pointer);
		ld("saved pc", MODE_DP, 8'h7F, 8'h00, 16'h007F, pc[15:8]);
		run(OP_SUBROUTINE_RETURN, MODE_DP, SEL_ACC, 8'h00, 8'h00, 8'h00);
		chk("return", {pc, 8'h7F}, {result.pc, core.stack_pointer});
		cpu.write_reg(SEL_STATUS, 8'hA5);
		run(OP_INTR, MODE_DP, SEL_ACC, 8'h00, 8'h00, 8'h00);
		chk("sp intr", 8'h7C, core.stack_pointer);
		cpu.write_reg(SEL_STATUS, 8'h00);
		run(OP_INTERRUPT_RETURN, MODE_DP, SEL_ACC, 8'h00, 8'h00, 8'h00);
		chk("intr return", {pc, 16'hA57F}, {result.pc, core.program_status_word, core.stack_pointer});
		// index and pointer modes over a small table in ram
		st(8'h31, 8'h00);
		st(8'h50, 8'($random(seed)));
		st(8'h52, 8'($random(seed)));
		cpu.write_reg(SEL_X, 8'h30);
		run(OP_STORE, MODE_X_INC, SEL_ACC, 8'h00, 8'h00, 8'h50);
		chk("x inc", 8'h31, core.x);
		ld("x only", MODE_X, 8'h00, 8'h00, 16'h0031, 8'h00);
		cpu.write_reg(SEL_X, 8'h40);
		ld("dp x wrap", MODE_DP_X, 8'hF0, 8'h00, 16'h0030, 8'h50);
		ld("x indirect", MODE_DP_X_IND, 8'hF0, 8'h00, 16'h0050, mem[8'h50]);
		cpu.write_reg(SEL_Y, 8'h02);
		ld("dp y", MODE_DP_Y, 8'h2E, 8'h00, 16'h0030, 8'h50);
		ld("indirect y", MODE_DP_IND_Y, 8'h30, 8'h00, 16'h0052, mem[8'h52]);
		ld("abs y", MODE_ABS_Y, 8'hFE, 8'h12, 16'h1300, 8'h00);
		run(OP_RMW, MODE_ABS, SEL_ACC, 8'h50, 8'h00, 8'h00);
		mem[8'h50] = mem[8'h50] + 8'h01;
		ld("abs rmw", MODE_ABS, 8'h50, 8'h00, 16'h0050, mem[8'h50]);
		run(OP_TARGET, MODE_DP_IND, SEL_ACC, 8'h30, 8'h00, 8'h00);
		chk("jump target", 16'h0050, result.ea);
		// every modifier on one ram byte, carry and value against the model
		for (int i = 0; i < 7; i++) begin
			fn = rmw_type'(i);
			e = {core.program_status_word[CARRY_BIT], mem[8'h52]};
			case (fn)
				RMW_SHL: e = {mem[8'h52], 1'b0};
				RMW_SHR: e = {mem[8'h52][0], 1'b0, mem[8'h52][7:1]};
				RMW_ROL: e = {mem[8'h52], e[8]};
				RMW_ROR: e = {mem[8'h52][0], e[8], mem[8'h52][7:1]};
				RMW_INC: e[7:0] = mem[8'h52] + 8'h01;
				RMW_DEC: e[7:0] = mem[8'h52] - 8'h01;
				default: ;
			endcase
			run(OP_RMW, MODE_ABS, SEL_ACC, 8'h52, 8'h00, 8'h00);
			chk("rmw", e, {core.program_status_word[CARRY_BIT], result.data});
			mem[8'h52] = e[7:0];
		end
		// reset in mid run restores the map but leaves the stack pointer alone
		rst_n = 1'b0;
		@(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("sp kept", {8'h7F, RESET_CLOCK_CTRL}, {core.stack_pointer, ctrl.clock_interval_control});
		tally_and_finish();
	end
	// limit on the whole run, far beyond the few hundred cycles it needs
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule : data_memory_map_and_addressing_test
`default_nettype wire
